// *** logic/pfsc_defines.svh ***
/*
  Constants of the fault and serial control block: slave address codes, register
  offsets, field positions and reset values.
  Assumes it is included by its bare name ahead of the package and the design.
*/
`ifndef PFSC_DEFINES_SVH
`define PFSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// slave address
// ----------------------------------------------------------------------------
`define PFSC_GROUP_CODE     4'h9
`define PFSC_DEVICE_CODE    3'h0

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define PFSC_REG_FAULT_FLAGS_FIRST    8'h00
`define PFSC_REG_STATUS2    8'h01
`define PFSC_REG_ENABLE     8'h02
`define PFSC_REG_VOLTAGE_ADJUST_REG    8'h03

// fault_flags_first fields
`define PFSC_ST1_BROWNOUT   0
`define PFSC_ST1_HOT        1
`define PFSC_ST1_SHUTDOWN   2
`define PFSC_ST1_USB1_FLT   3
`define PFSC_ST1_USB2_FLT   4
`define PFSC_ST1_UVLO       5
// second status register fields
`define PFSC_ST2_PG_LSB     0
`define PFSC_ST2_UV_LSB     3
// enable register fields
`define PFSC_EN_CONV_LSB    0
`define PFSC_EN_USB_LSB     3
`define PFSC_EN_VACT_LSB    5
// voltage_adjust_reg fields
`define PFSC_VADJ_C2_LSB    0
`define PFSC_VADJ_C3_LSB    2

// ----------------------------------------------------------------------------
// reset values and bit counts
// ----------------------------------------------------------------------------
`define PFSC_ENABLE_RST     8'h00
`define PFSC_VADJ_RST       8'h00
`define PFSC_STATUS_RST     8'h00
`define PFSC_LAST_BIT       4'h7
`define PFSC_ACK_BIT        4'h8

`endif

// *** logic/pfsc_pkg.sv ***
/*
  Types of the fault and serial control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pfsc_pkg;

  // link phase of the serial slave
  typedef enum logic [2:0] {
    PFSC_LK_ADDR   = 3'h0,
    PFSC_LK_SUB    = 3'h1,
    PFSC_LK_WR     = 3'h2,
    PFSC_LK_RD     = 3'h3,
    PFSC_LK_IGNORE = 3'h4
  } pfsc_link_e;

  typedef logic [7:0] pfsc_byte_t;

endpackage : pfsc_pkg

// *** logic/pfsc_fault_serial_ctrl.sv ***
/*
  Fault supervision, power-path enables, voltage scaling and the two-wire serial
  slave of a multi-rail power manager, with a small synchroniser module.
  Assumes comparator outputs and pins are asynchronous to sys_clk, the serial
  clock pin is also the link clock, and open-drain wires are resolved outside.
*/
// What this block does
// - main supply below warning: both USB paths off, alert driven low
// - main supply below lockout: all three converters off
// - converter supply low while converter 2 or 3 requested: all converters off
// - USB supply low while a USB switch requested: both switches off
// - lockouts are not latched; they end when the supply recovers
// - converter enable pins held discharged during any lockout or shutdown
// - serial mode: lockout clears converter and USB enable bits 4:0, keeps bits 7:5, and raises interrupt
// - after a fault, restart needs host bit writes or converter pins high
// - overtemperature shutdown turns off all converters and USB switches
// - near-shutdown temperature drives alert low; serial mode flags it too
// - serial mode: shutdown clears enable bits 4:0, raises interrupt, ends on cooling
// - serial mode only when the select comparator says high pull-up
// - pin mode follows pins; serial USB follows bits, converters bits or pins
// - serial mode repurposes USB pins as clock, data, interrupt, scaling input
// - serial mode: every fault sets its status flag and the interrupt
// - status read clears flags; interrupt released once all flags clear
// - two-bit field for converters 2 and 3 selects 5, 10 or 15 percent reduction
// - scaling applies while scaling pin high or activate bit set
// - slave runs up to 400 kbit/s with auto-incrementing register address
// - respond only to group code 1001 and device code 000
// - acknowledge address, subaddress and data; advance address per data byte
// - brownout and hot flagged apart; reads never touch the alert output

`include "pfsc_defines.svh"

// ----------------------------------------------------------------------------
// two-flop synchroniser
// ----------------------------------------------------------------------------
module pfsc_sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : pfsc_sync2

// ----------------------------------------------------------------------------
// top
// ----------------------------------------------------------------------------
module pfsc_fault_serial_ctrl (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       reset,
  // analog comparator outputs
  input  wire logic       main_below_warn,
  input  wire logic       main_below_lockout,
  input  wire logic       conv_supply_low,
  input  wire logic       usb_supply_low,
  input  wire logic       temp_warn,
  input  wire logic       temp_shutdown,
  input  wire logic       serial_select_high,
  input  wire logic [1:0] usb_overcurrent,
  input  wire logic [2:0] pgood_fail,
  input  wire logic [2:0] converter_uv,
  // converter enable pins
  input  wire logic [2:0] converter_enable_pin_i,
  output logic      [2:0] converter_enable_pin_dis,
  // shared pins; the clock pin also clocks the serial link
  input  wire logic       usb1_enable_or_clock_pin,
  input  wire logic       usb2_enable_or_data_pin_i,
  output logic            usb2_enable_or_data_pin_o,
  output logic            usb2_enable_or_data_pin_oe,
  input  wire logic       usb1_fault_or_vscale_pin_i,
  output logic            usb1_fault_or_vscale_pin_o,
  output logic            usb1_fault_or_vscale_pin_oe,
  output logic            usb2_fault_or_irq_pin_o,
  output logic            usb2_fault_or_irq_pin_oe,
  output logic            brownout_hot_alert_n_o,
  output logic            brownout_hot_alert_n_oe,
  // power path control
  output logic      [2:0] converter_on,
  output logic      [1:0] usb_switch_on,
  output logic      [1:0] vscale_code_conv2,
  output logic      [1:0] vscale_code_conv3,
  output logic            serial_mode
);

  // --------------------------------------------------------------------------
  // input synchronisation
  // --------------------------------------------------------------------------
  logic [22:0] raw_in;
  logic [22:0] syn_in;
  logic        warn_s, lock_s, conv_low_s, usb_low_s, hot_s, tsd_s, sel_s;
  logic [1:0]  oc_s;
  logic [2:0]  pg_s, uv_s, conv_pin_s;
  logic        vpin_s, scl_s, sda_s, wr_tgl_s, rd_tgl_s;
  logic        wr_tgl_q, rd_tgl_q;

  assign raw_in = {rd_tgl_q, wr_tgl_q, usb2_enable_or_data_pin_i, usb1_enable_or_clock_pin,
                   usb1_fault_or_vscale_pin_i, converter_enable_pin_i, converter_uv, pgood_fail,
                   usb_overcurrent, serial_select_high, temp_shutdown, temp_warn,
                   usb_supply_low, conv_supply_low, main_below_lockout, main_below_warn};

  pfsc_sync2 #(.WIDTH(23)) u_sync (
    .clk      (sys_clk),
    .reset    (reset),
    .async_in (raw_in),
    .sync_out (syn_in)
  );

  assign {rd_tgl_s, wr_tgl_s, sda_s, scl_s, vpin_s, conv_pin_s, uv_s, pg_s, oc_s, sel_s,
          tsd_s, hot_s, usb_low_s, conv_low_s, lock_s, warn_s} = syn_in;

  // --------------------------------------------------------------------------
  // fault decisions
  // --------------------------------------------------------------------------
  logic [7:0] en_q, vadj_q, st1_q, st2_q;
  logic [1:0] usb_req;
  logic [2:0] conv_req;
  logic       uvlo_usb, uvlo_conv, uvlo_any, fault_any, fault_prev_q, fault_evt;

  // requests follow pins in pin mode; in serial mode USB follows bits only
  assign usb_req   = sel_s ? en_q[`PFSC_EN_USB_LSB +: 2] : {sda_s, scl_s};
  assign conv_req  = sel_s ? (en_q[`PFSC_EN_CONV_LSB +: 3] | conv_pin_s) : conv_pin_s;
  assign uvlo_usb  = warn_s | (usb_low_s & (|usb_req));
  assign uvlo_conv = lock_s | (conv_low_s & (conv_req[1] | conv_req[2]));
  assign uvlo_any  = uvlo_usb | uvlo_conv;
  // pure levels: nothing latches, recovery is immediate
  assign fault_any = uvlo_any | tsd_s;
  assign fault_evt = fault_any & ~fault_prev_q;

  // event edge detector
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      fault_prev_q <= 1'b0;
    end else begin
      fault_prev_q <= fault_any;
    end
  end

  // power path gating
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      converter_on             <= 3'h0;
      usb_switch_on            <= 2'h0;
      converter_enable_pin_dis <= 3'h0;
      serial_mode              <= 1'b0;
    end else begin
      converter_on             <= conv_req & {3{~(uvlo_conv | tsd_s)}};
      usb_switch_on            <= usb_req & {2{~(uvlo_usb | tsd_s)}};
      converter_enable_pin_dis <= {3{fault_any}};
      serial_mode              <= sel_s;
    end
  end

  // --------------------------------------------------------------------------
  // pins: open-drain drivers only ever pull low
  // --------------------------------------------------------------------------
  logic od_low_q;
  logic irq_any;

  assign irq_any = (|st1_q) | (|st2_q);

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      od_low_q                    <= 1'b0;
      brownout_hot_alert_n_oe     <= 1'b1;
      usb1_fault_or_vscale_pin_oe <= 1'b1;
      usb2_fault_or_irq_pin_oe    <= 1'b1;
    end else begin
      od_low_q                    <= 1'b0;
      // alert follows the conditions only, never the status registers
      brownout_hot_alert_n_oe     <= ~(warn_s | hot_s);
      // serial mode: fault pin 1 becomes the scaling input
      usb1_fault_or_vscale_pin_oe <= sel_s | ~oc_s[0];
      // serial mode interrupt is active high: released while pending
      usb2_fault_or_irq_pin_oe    <= sel_s ? irq_any : ~oc_s[1];
    end
  end

  assign brownout_hot_alert_n_o     = od_low_q;
  assign usb1_fault_or_vscale_pin_o = od_low_q;
  assign usb2_fault_or_irq_pin_o    = od_low_q;
  assign usb2_enable_or_data_pin_o  = od_low_q;

  // voltage scaling; code 0 means nominal, 1..3 are 5, 10, 15 percent down
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vscale_code_conv2 <= 2'h0;
      vscale_code_conv3 <= 2'h0;
    end else begin
      vscale_code_conv2 <= (sel_s & (vpin_s | en_q[`PFSC_EN_VACT_LSB]))
                           ? vadj_q[`PFSC_VADJ_C2_LSB +: 2] : 2'h0;
      vscale_code_conv3 <= (sel_s & (vpin_s | en_q[`PFSC_EN_VACT_LSB + 1]))
                           ? vadj_q[`PFSC_VADJ_C3_LSB +: 2] : 2'h0;
    end
  end

  // --------------------------------------------------------------------------
  // register file (system clock side)
  // --------------------------------------------------------------------------
  logic             wr_prev_q, rd_prev_q, wr_evt, rd_evt;
  pfsc_pkg::pfsc_byte_t wr_addr_q, wr_data_q, rd_addr_q, rd_word_q, rd_mux;
  logic [7:0]       set1, set2, clr1, clr2;

  assign wr_evt = wr_tgl_s ^ wr_prev_q;
  assign rd_evt = rd_tgl_s ^ rd_prev_q;

  // toggle edge detectors
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end else begin
      wr_prev_q <= wr_tgl_s;
      rd_prev_q <= rd_tgl_s;
    end
  end

  // enable register; a fault event beats a host write in the same cycle
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      en_q <= `PFSC_ENABLE_RST;
    end else if (!sel_s) begin
      en_q <= `PFSC_ENABLE_RST;
    end else if (fault_evt) begin
      en_q <= en_q & 8'hE0;
    end else if (wr_evt && wr_addr_q == `PFSC_REG_ENABLE) begin
      en_q <= wr_data_q;
    end
  end

  // scaling selections
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      vadj_q <= `PFSC_VADJ_RST;
    end else if (wr_evt && wr_addr_q == `PFSC_REG_VOLTAGE_ADJUST_REG) begin
      vadj_q <= wr_data_q;
    end
  end

  // flag sources: levels, so a persisting fault re-flags after a read
  always_comb begin
    set1 = 8'h00;
    set2 = 8'h00;
    if (sel_s) begin
      set1[`PFSC_ST1_BROWNOUT] = warn_s;
      set1[`PFSC_ST1_HOT]      = hot_s;
      set1[`PFSC_ST1_SHUTDOWN] = tsd_s;
      set1[`PFSC_ST1_USB1_FLT] = oc_s[0];
      set1[`PFSC_ST1_USB2_FLT] = oc_s[1];
      set1[`PFSC_ST1_UVLO]     = uvlo_any;
      set2[`PFSC_ST2_PG_LSB +: 3] = pg_s;
      set2[`PFSC_ST2_UV_LSB +: 3] = uv_s;
    end
  end

  // read clears exactly the bits handed out
  assign clr1 = (rd_evt && rd_addr_q == `PFSC_REG_FAULT_FLAGS_FIRST) ? st1_q : 8'h00;
  assign clr2 = (rd_evt && rd_addr_q == `PFSC_REG_STATUS2) ? st2_q : 8'h00;

  // status flags; set wins over the read clear
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st1_q <= `PFSC_STATUS_RST;
      st2_q <= `PFSC_STATUS_RST;
    end else if (!sel_s) begin
      st1_q <= `PFSC_STATUS_RST;
      st2_q <= `PFSC_STATUS_RST;
    end else begin
      st1_q <= (st1_q & ~clr1) | set1;
      st2_q <= (st2_q & ~clr2) | set2;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (rd_addr_q)
      `PFSC_REG_FAULT_FLAGS_FIRST: rd_mux = st1_q;
      `PFSC_REG_STATUS2: rd_mux = st2_q;
      `PFSC_REG_ENABLE:  rd_mux = en_q;
      `PFSC_REG_VOLTAGE_ADJUST_REG: rd_mux = vadj_q;
      default:           rd_mux = 8'h00;
    endcase
  end

  // read word captured per request and held still for the link to sample
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_word_q <= 8'h00;
    end else if (rd_evt) begin
      rd_word_q <= rd_mux;
    end
  end

  // --------------------------------------------------------------------------
  // frame detection: start and stop reset the link logic
  // --------------------------------------------------------------------------
  logic sda_prev_q, link_rst_q;

  // the link clock stands still around start and stop, so the system clock
  // sees them and clears the link; the bus is low long before the next edge
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sda_prev_q <= 1'b1;
      link_rst_q <= 1'b1;
    end else begin
      sda_prev_q <= sda_s;
      link_rst_q <= (scl_s & (sda_prev_q ^ sda_s)) | ~sel_s;
    end
  end

  // --------------------------------------------------------------------------
  // serial link (link clock side)
  // --------------------------------------------------------------------------
  pfsc_pkg::pfsc_link_e lk_state_q;
  logic [3:0]           bit_cnt_q;
  logic [6:0]           shift_q, tx_q;
  logic                 ack_q, rnw_q, byte_done;
  pfsc_pkg::pfsc_byte_t byte_in, ptr_q;

  assign byte_in   = {shift_q, usb2_enable_or_data_pin_i};
  assign byte_done = (bit_cnt_q == `PFSC_LAST_BIT);

  // bit counter, shifter and phase
  always_ff @(posedge usb1_enable_or_clock_pin or posedge link_rst_q) begin
    if (link_rst_q) begin
      lk_state_q <= pfsc_pkg::PFSC_LK_ADDR;
      bit_cnt_q  <= 4'h0;
      shift_q    <= 7'h00;
      ack_q      <= 1'b0;
      rnw_q      <= 1'b0;
    end else if (bit_cnt_q != `PFSC_ACK_BIT) begin
      shift_q   <= byte_in[6:0];
      bit_cnt_q <= bit_cnt_q + 4'h1;
      if (byte_done) begin
        ack_q <= 1'b0;
        case (lk_state_q)
          pfsc_pkg::PFSC_LK_ADDR: begin
            if (byte_in[7:4] == `PFSC_GROUP_CODE && byte_in[3:1] == `PFSC_DEVICE_CODE) begin
              ack_q <= 1'b1;
              rnw_q <= byte_in[0];
            end else begin
              lk_state_q <= pfsc_pkg::PFSC_LK_IGNORE;
            end
          end
          pfsc_pkg::PFSC_LK_SUB,
          pfsc_pkg::PFSC_LK_WR: ack_q <= 1'b1;
          default: ack_q <= 1'b0;
        endcase
      end
    end else begin
      bit_cnt_q <= 4'h0;
      ack_q     <= 1'b0;
      case (lk_state_q)
        pfsc_pkg::PFSC_LK_ADDR: lk_state_q <= rnw_q ? pfsc_pkg::PFSC_LK_RD : pfsc_pkg::PFSC_LK_SUB;
        pfsc_pkg::PFSC_LK_SUB:  lk_state_q <= pfsc_pkg::PFSC_LK_WR;
        // a host not-acknowledge ends the read
        pfsc_pkg::PFSC_LK_RD: begin
          if (usb2_enable_or_data_pin_i) begin
            lk_state_q <= pfsc_pkg::PFSC_LK_IGNORE;
          end
        end
        default: lk_state_q <= lk_state_q;
      endcase
    end
  end

  // pointer and hand-off words survive repeated starts; only reset clears them
  always_ff @(posedge usb1_enable_or_clock_pin or posedge reset) begin
    if (reset) begin
      ptr_q     <= 8'h00;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
      wr_tgl_q  <= 1'b0;
      rd_addr_q <= 8'h00;
      rd_tgl_q  <= 1'b0;
    end else if (!link_rst_q && byte_done && lk_state_q == pfsc_pkg::PFSC_LK_SUB) begin
      ptr_q <= byte_in;
    end else if (!link_rst_q && byte_done && lk_state_q == pfsc_pkg::PFSC_LK_WR) begin
      wr_addr_q <= ptr_q;
      wr_data_q <= byte_in;
      wr_tgl_q  <= ~wr_tgl_q;
      ptr_q     <= ptr_q + 8'h01;
    end else if (!link_rst_q && bit_cnt_q == `PFSC_ACK_BIT) begin
      if (lk_state_q == pfsc_pkg::PFSC_LK_ADDR && rnw_q) begin
        rd_addr_q <= ptr_q;
        rd_tgl_q  <= ~rd_tgl_q;
      end else if (lk_state_q == pfsc_pkg::PFSC_LK_RD && !usb2_enable_or_data_pin_i) begin
        ptr_q     <= ptr_q + 8'h01;
        rd_addr_q <= ptr_q + 8'h01;
        rd_tgl_q  <= ~rd_tgl_q;
      end
    end
  end

  // data line driver changes on the falling clock edge
  always_ff @(negedge usb1_enable_or_clock_pin or posedge link_rst_q) begin
    if (link_rst_q) begin
      usb2_enable_or_data_pin_oe <= 1'b1;
      tx_q                       <= 7'h00;
    end else if (bit_cnt_q == `PFSC_ACK_BIT) begin
      usb2_enable_or_data_pin_oe <= ~ack_q;
    end else if (lk_state_q == pfsc_pkg::PFSC_LK_RD && bit_cnt_q == 4'h0) begin
      // word settled half a bit ago; it is quiet here
      usb2_enable_or_data_pin_oe <= rd_word_q[7];
      tx_q                       <= rd_word_q[6:0];
    end else if (lk_state_q == pfsc_pkg::PFSC_LK_RD) begin
      usb2_enable_or_data_pin_oe <= tx_q[6];
      tx_q                       <= {tx_q[5:0], 1'b0};
    end else begin
      usb2_enable_or_data_pin_oe <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  usb_warn_off_a: assert property (warn_s |=> usb_switch_on == 2'h0 && !brownout_hot_alert_n_oe)
    else $error("usb paths or alert wrong under brownout");
  conv_lockout_a: assert property (lock_s |=> converter_on == 3'h0)
    else $error("converters on under main lockout");
  conv_supply_a: assert property ((conv_low_s && (conv_req[1] || conv_req[2])) |=> converter_on == 3'h0)
    else $error("converters on under converter supply lockout");
  usb_supply_a: assert property ((usb_low_s && usb_req != 2'h0) |=> usb_switch_on == 2'h0)
    else $error("usb switches on under usb supply lockout");
  uvlo_release_a: assert property ((!uvlo_conv && !tsd_s) |=> converter_on == $past(conv_req))
    else $error("converters not following requests after recovery");
  pin_discharge_a: assert property (fault_any |=> converter_enable_pin_dis == 3'h7)
    else $error("enable pins not discharged during fault");
  uvlo_clear_en_a: assert property ((sel_s && uvlo_any && !fault_prev_q) |=> en_q[4:0] == 5'h00 ##1 usb2_fault_or_irq_pin_oe)
    else $error("lockout did not clear enables and raise interrupt");
  tsd_off_a: assert property (tsd_s |=> converter_on == 3'h0 && usb_switch_on == 2'h0)
    else $error("power paths on during shutdown");
  hot_alert_a: assert property ((hot_s && sel_s) |=> !brownout_hot_alert_n_oe && st1_q[`PFSC_ST1_HOT])
    else $error("hot warning not flagged");
  pin_follow_a: assert property ((!sel_s && !fault_any) |=> converter_on == $past(conv_pin_s))
    else $error("converters not following pins in pin mode");
  irq_release_a: assert property ((sel_s && st1_q == 8'h00 && st2_q == 8'h00) |=> !usb2_fault_or_irq_pin_oe)
    else $error("interrupt not released with flags clear");
  vscale_apply_a: assert property ((sel_s && vpin_s) |=> vscale_code_conv2 == $past(vadj_q[1:0]))
    else $error("scaling not applied with pin high");

  enable_write_c: cover property (wr_evt && wr_addr_q == `PFSC_REG_ENABLE);
  status_read_c: cover property (rd_evt && rd_addr_q == `PFSC_REG_FAULT_FLAGS_FIRST && st1_q != 8'h00);
  serial_tsd_c: cover property (sel_s && tsd_s && !fault_prev_q);
  addr_ignore_c: cover property (@(posedge usb1_enable_or_clock_pin) lk_state_q == pfsc_pkg::PFSC_LK_IGNORE);

endmodule : pfsc_fault_serial_ctrl

// *** verif/pfsc_host_model.sv ***
/* two-wire bus host model: start, stop and byte transfers.
   assumes the bench resolves the open-drain data line with a pull-up */
module pfsc_host_model (
  // bus lines
  output logic       scl,
  output logic       sda_low,
  input  wire logic  sda,
  // each byte seen on the wire, ack bit on top
  output logic [8:0] rx,
  output logic       got
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int Q = 625; // about 533 kHz; low phase 1.25 us clears the slave's minimum
  // clock stands high and data released between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    got = 1'b0;
  end
  // ---------------------------------------------------------------
  // bus conditions and bytes
  // ---------------------------------------------------------------
  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask : start
  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
  endtask : stop
  // data moves a third of a period after the falling edge, so hold is kept
  task automatic byte_io(input logic [7:0] w, input logic a);
    for (int i = 8; i >= 0; i--) begin
      #Q sda_low = ~((i > 0) ? w[i-1] : a);
      #Q scl = 1'b1;
      #(Q / 2) rx[(i + 8) % 9] = sda;
      #(Q / 2) scl = 1'b0;
    end
    got = 1'b1;
    #1 got = 1'b0;
  endtask : byte_io
endmodule : pfsc_host_model

// *** verif/testbench.sv ***
/* self-checking bench of the fault and serial control block.
   assumes the design files and the host model are compiled first */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset, main_below_warn, main_below_lockout, conv_supply_low, usb_supply_low;
  logic temp_warn, temp_shutdown, serial_select_high, usb1_fault_or_vscale_pin_i, usb1_fault_or_vscale_pin_oe;
  logic [1:0] usb_overcurrent, usb_switch_on, vscale_code_conv2, vscale_code_conv3;
  logic [2:0] pgood_fail, converter_uv, converter_enable_pin_i, converter_enable_pin_dis, converter_on;
  logic usb2_enable_or_data_pin_oe, usb2_fault_or_irq_pin_oe, brownout_hot_alert_n_oe, serial_mode;
  wire logic usb1_enable_or_clock_pin, sda_low, got;
  wire logic [8:0] rx;
  // open-drain data line with pull-up
  wire logic usb2_enable_or_data_pin_i = usb2_enable_or_data_pin_oe & ~sda_low;
  logic [8:0] exp_q[$];
  logic [31:0] rnd;
  int n_mismatch = 0;
  int n_compared = 0;
  pfsc_fault_serial_ctrl pfsc_fault_serial_ctrl_inst (.sys_clk, .reset, .main_below_warn, .main_below_lockout,
    .conv_supply_low, .usb_supply_low, .temp_warn, .temp_shutdown, .serial_select_high, .usb_overcurrent,
    .pgood_fail, .converter_uv, .converter_enable_pin_i, .converter_enable_pin_dis, .usb1_enable_or_clock_pin,
    .usb2_enable_or_data_pin_i, .usb2_enable_or_data_pin_o(), .usb2_enable_or_data_pin_oe,
    .usb1_fault_or_vscale_pin_i, .usb1_fault_or_vscale_pin_o(), .usb1_fault_or_vscale_pin_oe,
    .usb2_fault_or_irq_pin_o(), .usb2_fault_or_irq_pin_oe, .brownout_hot_alert_n_o(), .brownout_hot_alert_n_oe,
    .converter_on, .usb_switch_on, .vscale_code_conv2, .vscale_code_conv3, .serial_mode);
  pfsc_host_model pfsc_host_model_inst (.scl(usb1_enable_or_clock_pin), .sda_low, .sda(usb2_enable_or_data_pin_i),
    .rx, .got);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xs
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tx(input logic [7:0] w, input logic a, input logic [8:0] e);
    exp_q.push_back(e);
    pfsc_host_model_inst.byte_io(w, a);
  endtask : tx
  task automatic stop_test();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test
  // each byte on the wire is matched against the oldest note
  always @(posedge got) begin
    chk("bus byte", exp_q[0][7:0], rx[7:0]);
    chk("bus ack", {7'h00, exp_q[0][8]}, {7'h00, rx[8]});
    void'(exp_q.pop_front());
  end
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // a hung bus or missing pulse ends the run here
  initial begin
    #500us;
    n_mismatch++;
    stop_test();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {main_below_warn, main_below_lockout, conv_supply_low, usb_supply_low, temp_warn, temp_shutdown} = '0;
    {usb_overcurrent, pgood_fail, converter_uv, converter_enable_pin_i} = '0;
    {serial_select_high, usb1_fault_or_vscale_pin_i, reset} = 3'h7;
    rnd = xs(32'h0001004E);
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (20) @(posedge sys_clk);
    chk("mode", 8'h01, serial_mode);
    pfsc_host_model_inst.start();
    tx(8'h90, 1'b1, 9'h090);
    tx(8'h02, 1'b1, 9'h002);
    tx(8'h1F, 1'b1, 9'h01F);
    tx({4'h0, rnd[3:0]}, 1'b1, {5'h00, rnd[3:0]});
    pfsc_host_model_inst.stop();
    repeat (8) @(posedge sys_clk);
    chk("conv", 8'h07, converter_on);
    chk("usb", 8'h03, usb_switch_on);
    chk("vs2", rnd[1:0], vscale_code_conv2);
    chk("vs3", rnd[3:2], vscale_code_conv3);
    @(posedge sys_clk) {temp_warn, temp_shutdown, usb1_fault_or_vscale_pin_i, pgood_fail} <= 6'h32;
    repeat (8) @(posedge sys_clk);
    chk("conv", 8'h00, converter_on);
    chk("usb", 8'h00, usb_switch_on);
    chk("vs3", 8'h00, vscale_code_conv3);
    chk("dis", 8'h07, converter_enable_pin_dis);
    chk("alert", 8'h00, brownout_hot_alert_n_oe);
    chk("irq", 8'h01, usb2_fault_or_irq_pin_oe);
    @(posedge sys_clk) {temp_warn, temp_shutdown, pgood_fail} <= 5'h00;
    repeat (8) @(posedge sys_clk);
    chk("conv", 8'h00, converter_on);
    chk("dis", 8'h00, converter_enable_pin_dis);
    chk("alert", 8'h01, brownout_hot_alert_n_oe);
    pfsc_host_model_inst.start();
    tx(8'h90, 1'b1, 9'h090);
    tx(8'h00, 1'b1, 9'h000);
    pfsc_host_model_inst.start();
    tx(8'h91, 1'b1, 9'h091);
    tx(8'hFF, 1'b0, 9'h006);
    tx(8'hFF, 1'b0, 9'h002);
    tx(8'hFF, 1'b1, 9'h100);
    pfsc_host_model_inst.stop();
    repeat (8) @(posedge sys_clk);
    chk("irq", 8'h00, usb2_fault_or_irq_pin_oe);
    @(posedge sys_clk) main_below_lockout <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("irq", 8'h01, usb2_fault_or_irq_pin_oe);
    main_below_lockout <= 1'b0;
    pfsc_host_model_inst.start();
    tx(8'h92, 1'b1, 9'h192);
    pfsc_host_model_inst.stop();
    @(posedge sys_clk) {serial_select_high, converter_enable_pin_i, usb_overcurrent} <= 6'h17;
    repeat (8) @(posedge sys_clk);
    chk("mode", 8'h00, serial_mode);
    chk("conv", 8'h05, converter_on);
    chk("flt1", 8'h00, usb1_fault_or_vscale_pin_oe);
    @(posedge sys_clk) {main_below_warn, main_below_lockout} <= 2'h3;
    repeat (8) @(posedge sys_clk);
    chk("conv", 8'h00, converter_on);
    chk("usb", 8'h00, usb_switch_on);
    chk("alert", 8'h00, brownout_hot_alert_n_oe);
    @(posedge sys_clk) {main_below_warn, main_below_lockout} <= 2'h0;
    repeat (8) @(posedge sys_clk);
    chk("conv", 8'h05, converter_on);
    stop_test();
  end
endmodule : testbench
